// File: hdl/saiu_pkg.sv
// constants, types and register map of the sync activity interrupt unit
package saiu_pkg;

  // ==========================================================================
  // register map (printed offsets are indices, byte address is four times)
  localparam int          ADDR_W   = 8;
  localparam int          RDATA_W  = 32;
  localparam int          REG_W    = 8;
  localparam logic [7:0]  IDX_ACT  = 8'h03;
  localparam logic [7:0]  IDX_STAT = 8'h04;
  localparam logic [7:0]  IDX_MASK = 8'h05;
  localparam logic [7:0]  ADDR_ACT  = {IDX_ACT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_STAT = {IDX_STAT[5:0], 2'b00};
  localparam logic [7:0]  ADDR_MASK = {IDX_MASK[5:0], 2'b00};
  localparam logic [7:0]  MASK_RST  = 8'hff;
  localparam logic [7:0]  STAT_RST  = 8'h00;

  // ==========================================================================
  // field layout
  localparam int NCHAN        = 4;
  localparam int BIT_DISRUPT  = 4;
  localparam int BIT_SETTLE   = 5;
  localparam int BIT_VSYNC    = 6;
  localparam int BIT_PADJ     = 7;
  localparam int ACT_FIELD_W  = 4;
  localparam int ACT_FIRST_CH = 2;
  localparam int ACT_NCH      = 2;
  localparam int ACT_H        = 0;
  localparam int ACT_V        = 1;
  localparam int ACT_SOG_LSB  = 2;
  localparam int VIEW_W       = 6;
  localparam int SEL_VIEW_W   = 4;

  typedef enum logic [1:0] {
    SOG_NONE      = 2'b00,
    SOG_APERIODIC = 2'b01,
    SOG_PERIODIC  = 2'b10
  } saiu_sog_t;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS     = 10;
  localparam int HS_MAX_PERIOD_US  = 1000;
  localparam int VS_MAX_PERIOD_MS  = 50;
  // longest periods round down to whole cycles
  localparam int HS_TIMEOUT_CYC    = HS_MAX_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int VS_TIMEOUT_CYC    = VS_MAX_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TOL_CYC           = 4;
  localparam int CNT_W             = 24;

endpackage : saiu_pkg

// File: hdl/saiu_act_det.sv
// activity, polarity and stability detector for one sync input
`timescale 1ns/1ps
`default_nettype none
module saiu_act_det #(
  parameter int CNT_W   = 24,
  parameter int TIMEOUT = 100000,
  parameter int TOL     = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // sync level, already in the clock domain
  input  wire logic sig_i,
  // results
  output logic      active_o,
  output logic      toggled_o,
  output logic      stable_o,
  output logic      pol_low_o
);

  // ==========================================================================
  // segment measurement
  localparam logic [CNT_W-1:0] TO_C  = CNT_W'(TIMEOUT);
  localparam logic [CNT_W-1:0] TOL_C = CNT_W'(TOL);

  logic             sig_q;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] hi_r;
  logic [CNT_W-1:0] lo_r;
  logic [CNT_W-1:0] hi_prev_r;
  logic [CNT_W-1:0] lo_prev_r;
  logic             stable_r;
  logic             toggled_r;
  logic             active_r;
  logic             pol_low_r;

  wire              rise_w = sig_i & ~sig_q;
  wire              fall_w = ~sig_i & sig_q;
  wire              edge_w = rise_w | fall_w;
  wire              idle_w = (cnt_r == TO_C);
  wire [CNT_W:0]    per_sum = {1'b0, hi_r} + {1'b0, lo_r};
  wire              per_ok  = (per_sum < {1'b0, TO_C});

  function automatic logic close_enough(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    logic [CNT_W-1:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return (d <= TOL_C);
  endfunction : close_enough

  // a segment is steady only when both it and the opposite level repeat
  wire cnt_nxt_sel = edge_w;
  wire [CNT_W-1:0] cnt_nxt = cnt_nxt_sel ? '0 : (idle_w ? cnt_r : cnt_r + CNT_W'(1));
  wire stable_nxt = rise_w ? (close_enough(cnt_r, lo_r) && close_enough(hi_r, hi_prev_r)) :
                    fall_w ? (close_enough(cnt_r, hi_r) && close_enough(lo_r, lo_prev_r)) :
                    idle_w ? 1'b0 : stable_r;
  wire toggled_nxt = edge_w ? 1'b1 : (idle_w ? 1'b0 : toggled_r);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sig_q     <= 1'b0;
      cnt_r     <= '0;
      stable_r  <= 1'b0;
      toggled_r <= 1'b0;
    end else begin
      sig_q     <= sig_i;
      cnt_r     <= cnt_nxt;
      stable_r  <= stable_nxt;
      toggled_r <= toggled_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_r      <= '0;
      lo_r      <= '0;
      hi_prev_r <= '0;
      lo_prev_r <= '0;
    end else if (rise_w) begin
      lo_r      <= cnt_r;
      lo_prev_r <= lo_r;
    end else if (fall_w) begin
      hi_r      <= cnt_r;
      hi_prev_r <= hi_r;
    end
  end

  // ==========================================================================
  // results, one cycle behind the measurement
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_r  <= 1'b0;
      pol_low_r <= 1'b0;
    end else begin
      active_r  <= stable_r & toggled_r & per_ok;
      pol_low_r <= (hi_r > lo_r);
    end
  end

  assign active_o  = active_r;
  assign toggled_o = toggled_r;
  assign stable_o  = stable_r;
  assign pol_low_o = pol_low_r;

  // ==========================================================================
  // checks
  a_idle_drop: assert property (@(posedge clk) disable iff (!rstn)
    (idle_w && !edge_w) |=> !toggled_r ##1 !active_r)
    else $error("activity did not drop after idle timeout");

endmodule : saiu_act_det
`default_nettype wire

// File: hdl/saiu_top.sv
// sync activity status, event flags, mask and interrupt behind an apb slave
`timescale 1ns/1ps
`default_nettype none
module saiu_top #(
  parameter int HS_TIMEOUT = saiu_pkg::HS_TIMEOUT_CYC,
  parameter int VS_TIMEOUT = saiu_pkg::VS_TIMEOUT_CYC,
  parameter int TOL        = saiu_pkg::TOL_CYC
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [saiu_pkg::ADDR_W-1:0] paddr,
  input  wire logic [saiu_pkg::RDATA_W-1:0] pwdata,
  output logic [saiu_pkg::RDATA_W-1:0]     prdata,
  output logic                             pready,
  output logic                             pslverr,
  // sync inputs, one bit per channel
  input  wire logic [saiu_pkg::NCHAN-1:0]  hsync_in,
  input  wire logic [saiu_pkg::NCHAN-1:0]  vsync_in,
  input  wire logic [saiu_pkg::NCHAN-1:0]  green_channel_sync_in,
  // selection and phase adjustment
  input  wire logic [1:0]                  sel_chan,
  input  wire logic                        phase_adjust_done,
  // interrupt
  output logic                             irq
);

  localparam int NCH = saiu_pkg::NCHAN;
  localparam int RW  = saiu_pkg::REG_W;

  // ==========================================================================
  // per-channel detectors
  logic [NCH-1:0]             h_act;
  logic [NCH-1:0]             h_pol;
  logic [NCH-1:0]             h_stab;
  logic [NCH-1:0]             v_act;
  logic [NCH-1:0]             v_pol;
  logic [NCH-1:0]             v_stab;
  logic [NCH-1:0]             s_act;
  logic [NCH-1:0]             s_tog;
  logic [NCH-1:0]             chg_evt;
  saiu_pkg::saiu_sog_t        sog_code  [NCH];
  logic [saiu_pkg::VIEW_W-1:0] chan_view [NCH];
  logic [saiu_pkg::VIEW_W-1:0] chan_view_q [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    saiu_act_det #(.CNT_W(saiu_pkg::CNT_W), .TIMEOUT(HS_TIMEOUT), .TOL(TOL)) u_h (
      .clk       (core_clk),
      .rstn      (rstn),
      .sig_i     (hsync_in[c]),
      .active_o  (h_act[c]),
      .toggled_o (),
      .stable_o  (h_stab[c]),
      .pol_low_o (h_pol[c])
    );
    saiu_act_det #(.CNT_W(saiu_pkg::CNT_W), .TIMEOUT(VS_TIMEOUT), .TOL(TOL)) u_v (
      .clk       (core_clk),
      .rstn      (rstn),
      .sig_i     (vsync_in[c]),
      .active_o  (v_act[c]),
      .toggled_o (),
      .stable_o  (v_stab[c]),
      .pol_low_o (v_pol[c])
    );
    saiu_act_det #(.CNT_W(saiu_pkg::CNT_W), .TIMEOUT(HS_TIMEOUT), .TOL(TOL)) u_s (
      .clk       (core_clk),
      .rstn      (rstn),
      .sig_i     (green_channel_sync_in[c]),
      .active_o  (s_act[c]),
      .toggled_o (s_tog[c]),
      .stable_o  (),
      .pol_low_o ()
    );

    assign sog_code[c] = s_act[c] ? saiu_pkg::SOG_PERIODIC :
                         (s_tog[c] ? saiu_pkg::SOG_APERIODIC : saiu_pkg::SOG_NONE);
    assign chan_view[c] = {h_act[c], v_act[c], sog_code[c], h_pol[c], v_pol[c]};
    // first detection after reset also counts as a change
    assign chg_evt[c] = (chan_view[c] != chan_view_q[c]);

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        chan_view_q[c] <= '0;
      end else begin
        chan_view_q[c] <= chan_view[c];
      end
    end
  end

  // ==========================================================================
  // activity byte for channels 2 and 3
  logic [RW-1:0] act_byte;

  for (genvar k = 0; k < saiu_pkg::ACT_NCH; k++) begin : g_act
    localparam int CH = k + saiu_pkg::ACT_FIRST_CH;
    localparam int B  = k * saiu_pkg::ACT_FIELD_W;
    assign act_byte[B + saiu_pkg::ACT_H]          = h_act[CH];
    assign act_byte[B + saiu_pkg::ACT_V]          = v_act[CH];
    assign act_byte[B + saiu_pkg::ACT_SOG_LSB +: 2] = sog_code[CH];
  end

  // ==========================================================================
  // selected channel events
  wire [saiu_pkg::SEL_VIEW_W-1:0] sel_view = {h_act[sel_chan], v_act[sel_chan], h_pol[sel_chan], v_pol[sel_chan]};
  wire [1:0]                      sel_stab = {h_stab[sel_chan], v_stab[sel_chan]};
  wire                            vs_sel   = vsync_in[sel_chan];

  logic [saiu_pkg::SEL_VIEW_W-1:0] sel_view_q;
  logic [1:0]                      sel_stab_q;
  logic                            vs_sel_q;

  // losing stability means a timing change is under way
  wire disrupt_evt = (sel_view != sel_view_q) | (|(sel_stab_q & ~sel_stab));
  wire settle_evt  = |(sel_stab & ~sel_stab_q);
  wire vs_evt      = vs_sel & ~vs_sel_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sel_view_q <= '0;
      sel_stab_q <= '0;
      vs_sel_q   <= 1'b0;
    end else begin
      sel_view_q <= sel_view;
      sel_stab_q <= sel_stab;
      vs_sel_q   <= vs_sel;
    end
  end

  wire [RW-1:0] evt_vec = {phase_adjust_done, vs_evt, settle_evt, disrupt_evt, chg_evt};

  // ==========================================================================
  // apb decode, zero wait states
  wire setup_w  = psel & ~penable;
  wire access_w = psel & penable;
  wire hit_act  = (paddr == saiu_pkg::ADDR_ACT);
  wire hit_stat = (paddr == saiu_pkg::ADDR_STAT);
  wire hit_mask = (paddr == saiu_pkg::ADDR_MASK);
  wire hit_any  = hit_act | hit_stat | hit_mask;
  wire wr_stat  = access_w & pwrite & hit_stat;
  wire wr_mask  = access_w & pwrite & hit_mask;
  wire [RW-1:0] wr_byte = pwdata[RW-1:0];

  logic [RW-1:0] status_r;
  logic [RW-1:0] mask_r;
  logic [saiu_pkg::RDATA_W-1:0] prdata_r;
  logic          irq_r;

  wire [RW-1:0] clr_vec    = wr_stat ? wr_byte : '0;
  // set beats clear so an event in the clearing cycle survives
  wire [RW-1:0] status_nxt = (status_r & ~clr_vec) | evt_vec;
  wire [RW-1:0] mask_nxt   = wr_mask ? wr_byte : mask_r;
  wire [RW-1:0] rd_byte    = hit_act ? act_byte : (hit_stat ? status_r : (hit_mask ? mask_r : '0));
  wire          irq_nxt    = |(status_nxt & ~mask_nxt);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= saiu_pkg::STAT_RST;
      mask_r   <= saiu_pkg::MASK_RST;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= '0;
    end else if (setup_w && !pwrite) begin
      prdata_r <= {{(saiu_pkg::RDATA_W - RW){1'b0}}, rd_byte};
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = access_w & (~hit_any | (pwrite & hit_act));
  assign irq     = irq_r;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_stat;
    psel && penable && pwrite && hit_stat;
  endsequence

  sequence s_rd_act_setup;
    psel && !penable && !pwrite && hit_act;
  endsequence

  a_mask_after_reset: assert property ($rose(rstn) |-> (mask_r == saiu_pkg::MASK_RST) && !irq)
    else $error("mask not all ones or irq high after reset");

  a_w1c_clear: assert property ((s_wr_stat ##0 (evt_vec == '0)) |=> ((status_r & $past(wr_byte)) == '0))
    else $error("written one did not clear its flag");

  a_w1c_keep: assert property (s_wr_stat |=> (($past(status_r) & ~$past(wr_byte) & ~status_r) == '0))
    else $error("flag written with zero was cleared");

  a_set_wins: assert property ((evt_vec != '0) |=> ((status_r & $past(evt_vec)) == $past(evt_vec)))
    else $error("event lost against clear");

  a_chan_flag: assert property (chg_evt[2] |=> status_r[2] ##0 (irq == !mask_r[2] || irq))
    else $error("channel change flag not set");

  a_disrupt_flag: assert property (disrupt_evt |=> status_r[saiu_pkg::BIT_DISRUPT])
    else $error("disruption flag not set");

  a_settle_flag: assert property ((settle_evt && !mask_r[saiu_pkg::BIT_SETTLE] && !wr_mask)
    |=> status_r[saiu_pkg::BIT_SETTLE] && irq)
    else $error("settle flag or interrupt missing");

  a_vsync_irq: assert property ((vs_evt && !mask_r[saiu_pkg::BIT_VSYNC] && !wr_mask) |=> status_r[saiu_pkg::BIT_VSYNC] && irq)
    else $error("vsync did not interrupt");

  a_padj_irq: assert property ((phase_adjust_done && !mask_r[saiu_pkg::BIT_PADJ] && !wr_mask) |=> status_r[saiu_pkg::BIT_PADJ] ##0 irq)
    else $error("phase adjustment completion did not interrupt");

  a_irq_level: assert property (irq == |(status_r & ~mask_r))
    else $error("interrupt does not match unmasked flags");

  a_act_read: assert property (s_rd_act_setup |=> (prdata[RW-1:0] == $past(act_byte)) && (prdata[saiu_pkg::RDATA_W-1:RW] == '0))
    else $error("activity byte read wrong");

  // ==========================================================================
  // register access checks
  sequence s_rd_setup;
    psel && !penable && !pwrite;
  endsequence

  sequence s_rd_stat_access;
    psel && penable && !pwrite && hit_stat;
  endsequence

  a_stat_read: assert property ((s_rd_setup ##0 hit_stat) |=> prdata[RW-1:0] == $past(status_r))
    else $error("status byte read wrong");

  a_mask_read: assert property ((s_rd_setup ##0 hit_mask) |=> prdata[RW-1:0] == $past(mask_r))
    else $error("mask byte read wrong");

  a_rd_upper_zero: assert property (s_rd_setup |=> prdata[saiu_pkg::RDATA_W-1:RW] == '0)
    else $error("read data upper bits not zero");

  a_prdata_hold: assert property (!(setup_w && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside a read setup");

  a_read_keeps: assert property (s_rd_stat_access |=> (($past(status_r) & ~status_r) == '0))
    else $error("status read cleared a flag");

  a_mask_write: assert property ((psel && penable && pwrite && hit_mask) |=> mask_r == $past(wr_byte))
    else $error("mask write did not land");

  a_mask_keep: assert property (!wr_mask |=> mask_r == $past(mask_r))
    else $error("mask changed without a write");

  a_act_refused: assert property ((access_w && pwrite && hit_act) |-> pslverr)
    else $error("write to activity byte not refused");

  a_unmapped_err: assert property ((access_w && !hit_any) |-> pslverr)
    else $error("unmapped access not refused");

  a_ok_no_err: assert property ((access_w && hit_any && !(pwrite && hit_act)) |-> !pslverr)
    else $error("error on a legal access");

  a_err_idle: assert property (!access_w |-> !pslverr)
    else $error("error outside an access phase");

  // ==========================================================================
  // event flag checks
  a_no_spurious: assert property (((evt_vec == '0) && !wr_stat) |=> status_r == $past(status_r))
    else $error("flag changed without event or clear");

  a_vsync_flag: assert property (vs_evt |=> status_r[saiu_pkg::BIT_VSYNC])
    else $error("vsync flag not set");

  a_padj_flag: assert property (phase_adjust_done |=> status_r[saiu_pkg::BIT_PADJ])
    else $error("phase adjustment flag not set");

  a_settle_set: assert property (settle_evt |=> status_r[saiu_pkg::BIT_SETTLE])
    else $error("settle flag not set");

  a_disrupt_irq: assert property ((disrupt_evt && !mask_r[saiu_pkg::BIT_DISRUPT] && !wr_mask) |=> irq)
    else $error("unmasked disruption did not interrupt");

  // channels 0 and 1 only fire once their inputs carry sync
  for (genvar c = 0; c < NCH; c++) begin : g_chk
    a_chan_set: assert property (chg_evt[c] |=> status_r[c])
      else $error("channel change flag not set");

    a_chan_irq: assert property ((chg_evt[c] && !mask_r[c] && !wr_mask) |=> irq)
      else $error("unmasked channel change did not interrupt");
  end

endmodule : saiu_top
`default_nettype wire

// File: dv/saiu_sync_src.sv
// far-side sync sources: periodic hsync, vsync and green sync per channel
`timescale 1ns/1ps
`default_nettype none
module saiu_sync_src #(
  parameter int HP = 40,
  parameter int VP = 400
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // channel enables
  input  wire logic [3:0] en,
  // sync levels
  output logic      [3:0] hs,
  output logic      [3:0] vs,
  output logic      [3:0] gs
);
  // ==========================================================
  // counters; a disabled channel idles low, as a dead input would
  int hc;
  int vc;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hc <= 0;
      vc <= 0;
    end else begin
      hc <= (hc == HP - 1) ? 0 : hc + 1;
      vc <= (vc == VP - 1) ? 0 : vc + 1;
    end
  end
  assign hs = (hc < HP / 4) ? en : 4'h0;
  assign vs = (vc < VP / 20) ? en : 4'h0;
  assign gs = hs;
endmodule : saiu_sync_src
`default_nettype wire

// File: dv/tb_saiu_top.sv
// self-checking bench for the sync activity interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_saiu_top;
  // ==========================================================
  // signals
  logic                        core_clk   = 1'b0;
  logic                        rstn       = 1'b0;
  logic                        psel       = 1'b0;
  logic                        penable    = 1'b0;
  logic                        pwrite     = 1'b0;
  logic [saiu_pkg::ADDR_W-1:0] paddr      = 8'h00;
  logic [31:0]                 pwdata     = 32'h0;
  logic [31:0]                 prdata;
  logic                        pready;
  logic                        pslverr;
  logic [3:0]                  hs;
  logic [3:0]                  vs;
  logic [3:0]                  gs;
  logic [3:0]                  en         = 4'h0;
  logic [1:0]                  sel_chan   = 2'd2;
  logic                        padj       = 1'b0;
  logic                        irq;
  logic [7:0]                  rd;
  logic                        err;
  int                          errors     = 0;
  int                          n_compared = 0;

  always #5 core_clk = ~core_clk;

  // short timeouts keep idle detection within 200 cycles for hsync and green sync, 1000 for vsync
  saiu_top #(.HS_TIMEOUT(200), .VS_TIMEOUT(1000), .TOL(4)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hsync_in(hs), .vsync_in(vs),
    .green_channel_sync_in(gs), .sel_chan(sel_chan),
    .phase_adjust_done(padj), .irq(irq));

  saiu_sync_src i_src (.clk(core_clk), .rstn(rstn), .en(en), .hs(hs), .vs(vs), .gs(gs));

  // ==========================================================
  // tasks
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd      = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(what, rd, exp);
  endtask : rchk

  // flags and irq land one edge after their cause; allow margin
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic pulse_padj;
    @(posedge core_clk);
    padj <= 1'b1;
    @(posedge core_clk);
    padj <= 1'b0;
    settle();
  endtask : pulse_padj

  task automatic wait_irq(input int lim);
    int i;
    i = 0;
    #1;
    while (irq !== 1'b1 && i < lim) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk("irq wait", {7'h0, irq}, 8'h01);
    if (irq !== 1'b1) wrap_up();
  endtask : wait_irq

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rchk("mask", saiu_pkg::ADDR_MASK, 8'hff);
    rchk("status", saiu_pkg::ADDR_STAT, 8'h00);
    rchk("activity", saiu_pkg::ADDR_ACT, 8'h00);
    chk("irq", {7'h0, irq}, 8'h00);
    $display("test reset done");
    apb(1'b1, saiu_pkg::ADDR_ACT, 8'h5a);
    chk("act write err", {7'h0, err}, 8'h01);
    apb(1'b0, 8'h3c, 8'h00);
    chk("unmapped err", {7'h0, err}, 8'h01);
    rchk("activity", saiu_pkg::ADDR_ACT, 8'h00);
    $display("test refused done");
    pulse_padj();
    rchk("status", saiu_pkg::ADDR_STAT, 8'h80);
    chk("irq", {7'h0, irq}, 8'h00);
    apb(1'b1, saiu_pkg::ADDR_MASK, 8'h7f);
    settle();
    chk("irq", {7'h0, irq}, 8'h01);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'h7f);
    rchk("status", saiu_pkg::ADDR_STAT, 8'h80);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'h80);
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    rchk("status", saiu_pkg::ADDR_STAT, 8'h00);
    pulse_padj();
    chk("irq", {7'h0, irq}, 8'h01);
    rchk("status", saiu_pkg::ADDR_STAT, 8'h80);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'hff);
    $display("test phase adjust done");
    apb(1'b1, saiu_pkg::ADDR_MASK, 8'hdf);
    en <= 4'hc;
    repeat (1500) @(posedge core_clk);
    rchk("activity", saiu_pkg::ADDR_ACT, 8'hbb);
    rchk("status", saiu_pkg::ADDR_STAT, 8'h7c);
    chk("irq", {7'h0, irq}, 8'h01);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'h20);
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    apb(1'b0, saiu_pkg::ADDR_STAT, 8'h00);
    chk("status", rd & 8'hbf, 8'h1c);
    $display("test activity done");
    apb(1'b1, saiu_pkg::ADDR_MASK, 8'hbf);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'hff);
    wait_irq(600);
    settle();
    rchk("status", saiu_pkg::ADDR_STAT, 8'h40);
    $display("test vsync done");
    apb(1'b1, saiu_pkg::ADDR_MASK, 8'hf7);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'hff);
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    @(posedge core_clk);
    en <= 4'h4;
    wait_irq(1500);
    repeat (1200) @(posedge core_clk);
    rchk("activity", saiu_pkg::ADDR_ACT, 8'h0b);
    apb(1'b0, saiu_pkg::ADDR_STAT, 8'h00);
    chk("status", rd & 8'h0f, 8'h08);
    $display("test channel loss done");
    apb(1'b1, saiu_pkg::ADDR_MASK, 8'hef);
    apb(1'b1, saiu_pkg::ADDR_STAT, 8'hff);
    settle();
    chk("irq", {7'h0, irq}, 8'h00);
    @(posedge core_clk);
    sel_chan <= 2'd3;
    wait_irq(50);
    apb(1'b0, saiu_pkg::ADDR_STAT, 8'h00);
    chk("status", rd & 8'hbf, 8'h10);
    $display("test disruption done");
    wrap_up();
  end
endmodule : tb_saiu_top
`default_nettype wire
